// ==== src/cond_if.sv ====
// Conditioned pin levels passed from the input conditioner to the supervisor.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface cond_if;
  logic supply_low;
  logic strobe_mid;
  logic strobe_edge;

  modport producer (output supply_low, output strobe_mid, output strobe_edge);
  modport consumer (input supply_low, input strobe_mid, input strobe_edge);
endinterface

// ==== src/input_conditioner.sv ====
// Three-flop synchronisers for the comparator and strobe decode pins, plus strobe edge detection.
// Assumes raw pins are asynchronous to clk; outputs are registered.
`timescale 1ns/10ps
module input_conditioner (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   supply_low_raw,
  input  wire logic   strobe_high_raw,
  input  wire logic   strobe_low_raw,
  cond_if.producer    cond
);

  logic [supervisor_pkg::LANES-1:0] s1_r;
  logic [supervisor_pkg::LANES-1:0] s2_r;
  logic [supervisor_pkg::LANES-1:0] s3_r;
  logic [supervisor_pkg::LANES-1:0] stable_r;
  logic [supervisor_pkg::LANES-1:0] stable_nxt;
  logic                             edge_r;
  logic                             edge_nxt;

  // A strobe code counts as driven only when exactly one level is seen
  function automatic logic driven(input logic [supervisor_pkg::LANES-1:0] v);
    logic [1:0] code;
    code = {v[supervisor_pkg::LANE_HIGH], v[supervisor_pkg::LANE_LOW]};
    driven = (code == supervisor_pkg::STROBE_HIGH) || (code == supervisor_pkg::STROBE_LOW);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    for (int i = 0; i < supervisor_pkg::LANES; i++) begin
      // First stage is read only by the second
      stable_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : stable_r[i];
    end
    // Both directions of change count; a move to mid is not servicing
    edge_nxt = driven(stable_nxt) &&
               ((stable_nxt[supervisor_pkg::LANE_HIGH] != stable_r[supervisor_pkg::LANE_HIGH]) ||
                (stable_nxt[supervisor_pkg::LANE_LOW] != stable_r[supervisor_pkg::LANE_LOW]));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r     <= supervisor_pkg::SYNC_RESET;
      s2_r     <= supervisor_pkg::SYNC_RESET;
      s3_r     <= supervisor_pkg::SYNC_RESET;
      stable_r <= supervisor_pkg::SYNC_RESET;
      edge_r   <= 1'b0;
    end else begin
      s1_r     <= {strobe_low_raw, strobe_high_raw, supply_low_raw};
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      stable_r <= stable_nxt;
      edge_r   <= edge_nxt;
    end
  end

  assign cond.supply_low  = stable_r[supervisor_pkg::LANE_SUPPLY];
  assign cond.strobe_mid  = !driven(stable_r);
  assign cond.strobe_edge = edge_r;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_edge_driven: assert property (edge_r |-> !cond.strobe_mid) else $error("strobe edge on mid level");
  chk_edge_agree: assert property (edge_nxt |->
      s2_r[supervisor_pkg::LANE_HIGH] == s3_r[supervisor_pkg::LANE_HIGH])
    else $error("strobe edge taken before stages agree");

endmodule

// ==== src/supervisor_pkg.sv ====
// Constants shared by the supply and watchdog supervisor.
// Assumes a single 20 MHz timebase feeding every clocked process.
package supervisor_pkg;

  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CYCLES_PER_MS   = CLK_HZ / 1000;

  // Least reset active time, in milliseconds
  localparam int unsigned RESET_ACTIVE_MS = 140;
  // Watchdog timeout: typical, least and longest, in milliseconds
  localparam int unsigned TIMEOUT_TYP_MS  = 1600;
  localparam int unsigned TIMEOUT_MIN_MS  = 1000;
  localparam int unsigned TIMEOUT_MAX_MS  = 2250;

  localparam int unsigned CNT_W           = 26;

  localparam logic [CNT_W-1:0] RESET_ACTIVE_CYCLES = CNT_W'(RESET_ACTIVE_MS * CYCLES_PER_MS);
  localparam logic [CNT_W-1:0] TIMEOUT_CYCLES      = CNT_W'(TIMEOUT_TYP_MS * CYCLES_PER_MS);
  localparam logic [CNT_W-1:0] TIMEOUT_MIN_CYCLES  = CNT_W'(TIMEOUT_MIN_MS * CYCLES_PER_MS);
  localparam logic [CNT_W-1:0] TIMEOUT_MAX_CYCLES  = CNT_W'(TIMEOUT_MAX_MS * CYCLES_PER_MS);

  // Synchroniser lanes
  localparam int unsigned LANE_SUPPLY = 0;
  localparam int unsigned LANE_HIGH   = 1;
  localparam int unsigned LANE_LOW    = 2;
  localparam int unsigned LANES       = 3;
  localparam logic [LANES-1:0] SYNC_RESET = 3'h0;

  // Decoded strobe codes {high, low}
  localparam logic [1:0] STROBE_HIGH = 2'h2;
  localparam logic [1:0] STROBE_LOW  = 2'h1;

endpackage

// ==== src/supply_watchdog_supervisor.sv ====
// Supply supervisor and watchdog: reset hold after supply recovery, watchdog reset pulses and fault flag.
// Assumes supply-low and three-level strobe decode arrive as asynchronous digital pins.
`timescale 1ns/10ps
module supply_watchdog_supervisor #(
  parameter logic [supervisor_pkg::CNT_W-1:0] RESET_CYCLES   = supervisor_pkg::RESET_ACTIVE_CYCLES,
  parameter logic [supervisor_pkg::CNT_W-1:0] TIMEOUT_CYCLES = supervisor_pkg::TIMEOUT_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic supply_low_in,
  input  wire logic strobe_high_in,
  input  wire logic strobe_low_in,
  output logic      reset_out_n,
  output logic      reset_out,
  output logic      watchdog_fault_out_n
);

  typedef enum logic [1:0] {ST_SUPPLY_LOW, ST_HOLD, ST_RUN} state_type;

  cond_if cond ();

  state_type                          state_r;
  state_type                          state_nxt;
  logic [supervisor_pkg::CNT_W-1:0]   cnt_r;
  logic [supervisor_pkg::CNT_W-1:0]   cnt_nxt;
  logic                               fault_n_r;
  logic                               fault_n_nxt;
  logic                               reset_n_r;
  logic                               reset_n_nxt;
  logic                               reset_r;

  ////////////////////////////////////////////////////////////////////////////

  input_conditioner u_cond (
    .clk             (clk),
    .rst             (rst),
    .supply_low_raw  (supply_low_in),
    .strobe_high_raw (strobe_high_in),
    .strobe_low_raw  (strobe_low_in),
    .cond            (cond)
  );

  ////////////////////////////////////////////////////////////////////////////

  // One counter serves both hold time and watchdog timeout: they never run together
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    fault_n_nxt = fault_n_r;
    unique case (state_r)
      ST_SUPPLY_LOW: begin
        cnt_nxt = '0;
        if (!cond.supply_low) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt_r == RESET_CYCLES - 1'b1) begin
          state_nxt = ST_RUN;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_RUN: begin
        if (cond.strobe_mid || cond.strobe_edge) begin
          cnt_nxt = '0;
        end else if (cnt_r == TIMEOUT_CYCLES - 1'b1) begin
          state_nxt   = ST_HOLD;
          cnt_nxt     = '0;
          fault_n_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    endcase
    if (cond.strobe_edge || cond.strobe_mid) begin
      fault_n_nxt = 1'b1;
    end
    // Supply loss overrides everything; the hold restarts once it clears
    if (cond.supply_low) begin
      state_nxt   = ST_SUPPLY_LOW;
      cnt_nxt     = '0;
      fault_n_nxt = 1'b1;
    end
    reset_n_nxt = (state_nxt == ST_RUN);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // Power-up behaves like a supply recovery: full hold first
      state_r   <= ST_HOLD;
      cnt_r     <= '0;
      fault_n_r <= 1'b1;
      reset_n_r <= 1'b0;
      reset_r   <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      fault_n_r <= fault_n_nxt;
      reset_n_r <= reset_n_nxt;
      reset_r   <= !reset_n_nxt;
    end
  end

  assign reset_out_n          = reset_n_r;
  assign reset_out            = reset_r;
  assign watchdog_fault_out_n = fault_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [supervisor_pkg::CNT_W-1:0] low_len_r;
  logic [supervisor_pkg::CNT_W-1:0] low_len_nxt;
  logic [supervisor_pkg::CNT_W-1:0] run_len_r;
  logic [supervisor_pkg::CNT_W-1:0] run_len_nxt;

  // Helper counters: cycles with reset low, and quiet cycles of an enabled watchdog
  always_comb begin
    low_len_nxt = reset_n_r ? '0 : low_len_r + 1'b1;
    run_len_nxt = (state_r != ST_RUN || cond.strobe_mid || cond.strobe_edge || cond.supply_low)
                  ? '0 : run_len_r + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_len_r <= '0;
      run_len_r <= '0;
    end else begin
      low_len_r <= low_len_nxt;
      run_len_r <= run_len_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence timeout_hit;
    state_r == ST_RUN && cnt_r == TIMEOUT_CYCLES - 1'b1 && !cond.strobe_mid && !cond.strobe_edge
      && !cond.supply_low;
  endsequence

  sequence watchdog_reset;
    !reset_out_n && !watchdog_fault_out_n && reset_out;
  endsequence

  chk_supply_reset: assert property (cond.supply_low |=> !reset_out_n && reset_out)
    else $error("reset not asserted on supply low");

  chk_hold_length: assert property ($rose(reset_out_n) |-> low_len_r >= RESET_CYCLES)
    else $error("reset released before hold time");

  chk_timeout_pulse: assert property (timeout_hit |=> watchdog_reset)
    else $error("timeout did not give reset pulse and fault");

  chk_edge_clears: assert property (cond.strobe_edge && state_r == ST_RUN && !cond.supply_low |=> cnt_r == '0)
    else $error("strobe change did not clear counter");

  chk_repeat_pulse: assert property ($fell(reset_out_n) && watchdog_fault_out_n == 1'b0
      |-> !$past(cond.strobe_mid))
    else $error("watchdog pulse while disabled");

  chk_fault_rise: assert property (!watchdog_fault_out_n && cond.strobe_edge |=> watchdog_fault_out_n)
    else $error("fault not cleared by strobe change");

  // A running watchdog that sees mid level must not pull reset on the next cycle
  chk_mid_quiet: assert property (cond.strobe_mid |=> watchdog_fault_out_n
      && (reset_out_n || $past(state_r) != ST_RUN || $past(cond.supply_low)))
    else $error("watchdog active while strobe mid");

  chk_supply_fault: assert property (cond.supply_low |=> watchdog_fault_out_n)
    else $error("fault low during supply low");

  chk_reset_complement: assert property (reset_out == !reset_out_n)
    else $error("reset outputs not complementary");

  chk_timeout_range: assert property (run_len_r <= TIMEOUT_CYCLES
      && cnt_r <= supervisor_pkg::TIMEOUT_MAX_CYCLES)
    else $error("watchdog ran past its timeout");

  chk_restart_run: assert property ($rose(reset_out_n) |-> cnt_r == '0)
    else $error("watchdog did not restart after reset");

endmodule

// ==== testbench/strobe_host_model.sv ====
// Processor-side model driving the three-level watchdog strobe decode.
// Assumes the bench picks the mode and toggle period; changes land on clk rising edges.
`timescale 1ns/10ps
module strobe_host_model (
  input  wire logic       clk,
  input  wire logic [2:0] mode,
  input  wire logic [31:0] period,
  output logic            strobe_high_in,
  output logic            strobe_low_in
);
  int   cnt_r = 0;
  logic lvl_r = 1'b0;

  ////////////////////////////////////////////////////////////////
  // Mode 0 services the watchdog; 1 and 2 hang high or low; 3 and 4 are mid
  always @(posedge clk) begin
    cnt_r <= (cnt_r + 1 >= period) ? 0 : cnt_r + 1;
    if (mode == 3'h0 && cnt_r + 1 >= period) begin
      lvl_r <= ~lvl_r;
    end
    case (mode)
      3'h0: begin strobe_high_in <= lvl_r; strobe_low_in <= ~lvl_r; end
      3'h1: begin strobe_high_in <= 1'b1; strobe_low_in <= 1'b0; lvl_r <= 1'b1; end
      3'h2: begin strobe_high_in <= 1'b0; strobe_low_in <= 1'b1; lvl_r <= 1'b0; end
      3'h3: begin strobe_high_in <= 1'b0; strobe_low_in <= 1'b0; end
      default: begin strobe_high_in <= 1'b1; strobe_low_in <= 1'b1; end
    endcase
  end
endmodule

// ==== testbench/supply_watchdog_supervisor_tb.sv ====
// Self-checking bench for the supply and watchdog supervisor.
// Assumes short counts: hold 20 cycles, timeout 50 cycles, so the run stays brief.
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module supply_watchdog_supervisor_tb;
  localparam int RC = 20;
  localparam int TC = 50;
  logic       clk;
  logic       rst;
  logic       supply_low_in;
  logic [2:0] mode;
  int         period;
  logic       strobe_high_in;
  logic       strobe_low_in;
  logic       reset_out_n;
  logic       reset_out;
  logic       watchdog_fault_out_n;
  int         err_count;
  int         num_checks;
  int         n;
  logic [31:0] seed;
  logic [2:0]  pin_q[$];
  logic [2:0]  ref_stb;
  logic [2:0]  ref_nxt;
  logic        ref_edge;
  int          ref_state;
  int          ref_cnt;
  logic        ref_fault_n;
  logic        ref_reset_n;

  supply_watchdog_supervisor #(
    .RESET_CYCLES   (supervisor_pkg::CNT_W'(RC)),
    .TIMEOUT_CYCLES (supervisor_pkg::CNT_W'(TC))
  ) DUT (
    .clk                  (clk),
    .rst                  (rst),
    .supply_low_in        (supply_low_in),
    .strobe_high_in       (strobe_high_in),
    .strobe_low_in        (strobe_low_in),
    .reset_out_n          (reset_out_n),
    .reset_out            (reset_out),
    .watchdog_fault_out_n (watchdog_fault_out_n)
  );

  strobe_host_model host (
    .clk            (clk),
    .mode           (mode),
    .period         (period),
    .strobe_high_in (strobe_high_in),
    .strobe_low_in  (strobe_low_in)
  );

  ////////////////////////////////////////////////////////////////
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Exactly one of the two decoded levels means the strobe is driven
  function automatic logic one_level(input logic [2:0] v);
    return v[1] ^ v[2];
  endfunction

  // Reference model with integers: a pin counts once two stages agree, then hold and timeout
  // are counted in cycles; state 0 is supply low, 1 hold, 2 running
  always @(posedge clk) begin
    if (rst) begin
      pin_q = '{3'h0, 3'h0, 3'h0};
      ref_stb = 3'h0;
      ref_edge = 1'b0;
      ref_state = 1;
      ref_cnt = 0;
      ref_fault_n = 1'b1;
      ref_reset_n = 1'b0;
    end else begin
      if (ref_state == 0) begin
        ref_cnt = 0;
        if (!ref_stb[0]) begin
          ref_state = 1;
        end
      end else if (ref_state == 1) begin
        ref_cnt++;
        if (ref_cnt == RC) begin
          ref_state = 2;
          ref_cnt = 0;
        end
      end else if (!one_level(ref_stb) || ref_edge) begin
        ref_cnt = 0;
      end else begin
        ref_cnt++;
        if (ref_cnt == TC) begin
          ref_state = 1;
          ref_cnt = 0;
          ref_fault_n = 1'b0;
        end
      end
      if (!one_level(ref_stb) || ref_edge) begin
        ref_fault_n = 1'b1;
      end
      if (ref_stb[0]) begin
        ref_state = 0;
        ref_cnt = 0;
        ref_fault_n = 1'b1;
      end
      ref_reset_n = (ref_state == 2);
      ref_nxt = (pin_q[0] & ~(pin_q[0] ^ pin_q[1])) | (ref_stb & (pin_q[0] ^ pin_q[1]));
      ref_edge = one_level(ref_nxt) && (ref_nxt[2:1] != ref_stb[2:1]);
      ref_stb = ref_nxt;
      void'(pin_q.pop_front());
      pin_q.push_back({strobe_low_in, strobe_high_in, supply_low_in});
    end
  end

  always @(negedge clk) begin
    `CHK(reset_out, ~reset_out_n)
    `CHK(reset_out_n, ref_reset_n)
    `CHK(watchdog_fault_out_n, ref_fault_n)
  end

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Bounded wait for an output level; 0 selects reset_out_n, 1 the fault flag
  task automatic wait_for(input int which, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (((which == 0) ? reset_out_n : watchdog_fault_out_n) !== v) begin
      if (cnt >= lim) begin
        err_count++;
        $display("Error at %0t: wait ran out", $time);
        end_of_test();
      end
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask

  // Counts cycles in which either output is active
  task automatic watch(input int cycles, output int lows);
    lows = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if (reset_out_n !== 1'b1 || watchdog_fault_out_n !== 1'b1) lows++;
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    supply_low_in = 1'b0;
    mode = 3'h3;
    period = 10;
    err_count = 0;
    num_checks = 0;
    seed = 32'h34;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    wait_for(0, 1'b1, RC + 10, n);
    `CHK(n >= RC - 1, 1'b1)
    // Mid level both ways: no watchdog action
    for (int m = 3; m <= 4; m++) begin
      @(posedge clk);
      mode <= m[2:0];
      watch(3 * TC, n);
      `CHK(n, 0)
    end
    // Random service periods, all shorter than the timeout
    repeat (4) begin
      seed = xorshift(seed);
      @(posedge clk);
      mode <= 3'h0;
      period <= 4 + int'(seed % 32'h24);
      watch(2 * TC, n);
      `CHK(n, 0)
    end
    // Strobe stuck high, then stuck low
    for (int m = 1; m <= 2; m++) begin
      @(posedge clk);
      mode <= m[2:0];
      wait_for(0, 1'b0, TC + RC + 20, n);
      `CHK(watchdog_fault_out_n, 1'b0)
      wait_for(0, 1'b1, RC + 10, n);
      `CHK(n >= RC && n <= RC + 4, 1'b1)
      wait_for(0, 1'b0, TC + 10, n);
      `CHK(n * 1600 >= TC * 1000 && n * 1600 <= TC * 2250, 1'b1)
      @(posedge clk);
      mode <= 3'h0;
      period <= 6;
      // First toggle lands within one period, then five edges reach the output
      wait_for(1, 1'b1, 20, n);
      `CHK(n <= 12, 1'b1)
      wait_for(0, 1'b1, RC + 10, n);
    end
    // Supply drop while the fault flag is low
    @(posedge clk);
    mode <= 3'h2;
    wait_for(1, 1'b0, TC + RC + 20, n);
    @(posedge clk);
    supply_low_in <= 1'b1;
    wait_for(1, 1'b1, 8, n);
    `CHK(reset_out_n, 1'b0)
    repeat (30) @(posedge clk);
    supply_low_in <= 1'b0;
    mode <= 3'h0;
    wait_for(0, 1'b1, RC + 12, n);
    `CHK(n >= RC, 1'b1)
    // Supply drop from normal running
    watch(TC, n);
    `CHK(n, 0)
    @(posedge clk);
    supply_low_in <= 1'b1;
    wait_for(0, 1'b0, 8, n);
    `CHK(n <= 6, 1'b1)
    end_of_test();
  end
endmodule
